// File: rtl/arp_output_port.sv
/*
  result output port: two-entry result buffer, parallel, byte and dual-line serial reads.
  assumes results arrive on clk_i; host strobes are asynchronous pins; sclk_i runs only in frames.
*/
`timescale 1ns/1ps
module arp_output_port (
  input  wire logic                     clk_i,
  input  wire logic                     arst_n_i,
  input  wire logic                     ce_i,
  input  wire logic                     res_valid_i,
  output logic                          res_ready_o,
  input  wire logic [arp_pkg::RES_W-1:0] res_data_i,
  input  wire logic                     cs_n_i,
  input  wire logic                     rd_n_i,
  input  wire logic                     sclk_i,
  input  wire logic                     interface_select_i,
  input  wire logic                     ref_select_i,
  input  wire logic [arp_pkg::BUS_W-1:0] result_data_lines_i,
  output logic      [arp_pkg::BUS_W-1:0] result_data_lines_o,
  output logic      [arp_pkg::BUS_W-1:0] result_data_lines_oe_o,
  output logic                          int_ref_en_o
);
  arp_pkg::arp_pins_type  raw;
  arp_pkg::arp_pins_type  p;
  arp_pkg::arp_state_type r;
  arp_pkg::arp_state_type next_r;
  arp_pkg::arp_link_type  l;
  arp_pkg::arp_link_type  next_l;

  logic [arp_pkg::RES_W-1:0] head;
  logic [arp_pkg::RES_W-1:0] other;
  logic [3:0]                ser_pos;
  logic                      push;
  logic [1:0]                pop_n;
  logic                      cs_fall;
  logic                      rd_fall;
  logic                      rd_end;
  logic                      take_hi;
  logic                      par_on;

  always_comb begin
    raw.cs_n            = cs_n_i;
    raw.rd_n            = rd_n_i;
    raw.iface_sel       = interface_select_i;
    raw.byte_sel        = result_data_lines_i[arp_pkg::BSEL_LINE];
    raw.high_byte_first = result_data_lines_i[arp_pkg::HBF_LINE];
    raw.ref_select      = ref_select_i;
  end

  arp_sync2 #(
    .W   ($bits(arp_pkg::arp_pins_type)),
    .RST (arp_pkg::PINS_IDLE)
  ) u_pin_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .ce_i     (ce_i),
    .d_i      (raw),
    .q_o      (p)
  );

  assign head    = r.mem[r.rptr];
  assign other   = r.mem[~r.rptr];
  assign push    = res_valid_i && (r.cnt != arp_pkg::CNT_FULL);
  assign cs_fall = r.cs_q && !p.cs_n;
  assign rd_fall = r.rd_q && !p.rd_n && !p.cs_n;
  // a strobe ends on rising read, or when chip select leaves first
  assign rd_end  = !r.rd_q && !r.cs_q && (p.rd_n || p.cs_n);
  assign take_hi = (r.byte_idx == 1'b0) == p.high_byte_first;
  assign par_on  = !r.cs_q && !r.rd_q;

  always_comb begin
    next_r = r;
    pop_n  = 2'h0;
    if (ce_i) begin
      next_r.cs_q   = p.cs_n;
      next_r.rd_q   = p.rd_n;
      next_r.ref_en = p.ref_select;
      if (p.cs_n) begin
        next_r.byte_idx = 1'b0;
        if (!p.iface_sel) begin
          next_r.mode = arp_pkg::MODE_PAR;
        end else if (p.byte_sel) begin
          next_r.mode = arp_pkg::MODE_BYTE;
        end else begin
          next_r.mode = arp_pkg::MODE_SER;
        end
      end
      case (r.mode)
        arp_pkg::MODE_PAR: begin
          if (rd_fall) begin
            next_r.dout = {{2{head[arp_pkg::SIGN_BIT]}}, head};
          end
          if (rd_end && r.cnt != arp_pkg::CNT_EMPTY) begin
            pop_n = 2'h1;
          end
        end
        arp_pkg::MODE_BYTE: begin
          if (rd_fall) begin
            // msb of each byte lands on line 7
            next_r.dout = take_hi ?
              {8'h00, {2{head[arp_pkg::SIGN_BIT]}}, head[arp_pkg::SIGN_BIT:arp_pkg::HI_LSB]} :
              {8'h00, head[arp_pkg::BYTE_W-1:0]};
          end
          if (rd_end) begin
            next_r.byte_idx = !r.byte_idx;
            if (r.byte_idx && r.cnt != arp_pkg::CNT_EMPTY) begin
              pop_n = 2'h1;
            end
          end
        end
        arp_pkg::MODE_SER: begin
          // both words stay frozen for the whole frame, so the link side reads them safely
          if (cs_fall) begin
            next_r.word_a = head;
            next_r.word_b = (r.cnt == arp_pkg::CNT_FULL) ? other : '0;
            pop_n         = r.cnt;
          end
        end
        default: begin
          next_r.mode = arp_pkg::MODE_PAR;
        end
      endcase
      if (push) begin
        next_r.mem[r.wptr] = res_data_i;
        next_r.wptr        = !r.wptr;
      end
      next_r.rptr = r.rptr ^ pop_n[0];
      next_r.cnt  = r.cnt + {1'b0, push} - pop_n;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r        <= '0;
      r.cs_q   <= 1'b1;
      r.rd_q   <= 1'b1;
      r.mode   <= arp_pkg::MODE_PAR;
    end else begin
      r <= next_r;
    end
  end

  // link side: bit position, cleared while chip select is high
  always_comb begin
    next_l = l;
    if (l.bit_idx != arp_pkg::LAST_BIT) begin
      next_l.bit_idx = l.bit_idx + 4'h1;
    end
  end

  always_ff @(posedge sclk_i or negedge arst_n_i or posedge cs_n_i) begin
    if (!arst_n_i) begin
      l <= '0;
    end else if (cs_n_i) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  assign ser_pos = 4'(arp_pkg::SIGN_BIT) - l.bit_idx;

  assign res_ready_o  = r.cnt != arp_pkg::CNT_FULL;
  assign int_ref_en_o = r.ref_en;

  // lines 13..9 stay undriven outside full parallel mode
  always_comb begin
    result_data_lines_o    = r.dout;
    result_data_lines_oe_o = arp_pkg::OE_NONE;
    case (r.mode)
      arp_pkg::MODE_PAR: begin
        result_data_lines_oe_o = par_on ? arp_pkg::OE_ALL : arp_pkg::OE_NONE;
      end
      arp_pkg::MODE_BYTE: begin
        result_data_lines_oe_o = par_on ? arp_pkg::OE_BYTE : arp_pkg::OE_NONE;
      end
      arp_pkg::MODE_SER: begin
        result_data_lines_o[arp_pkg::SER_A_LINE] = r.word_a[ser_pos];
        result_data_lines_o[arp_pkg::SER_B_LINE] = r.word_b[ser_pos];
        result_data_lines_oe_o = !r.cs_q ? arp_pkg::OE_SER : arp_pkg::OE_NONE;
      end
      default: begin
        result_data_lines_oe_o = arp_pkg::OE_NONE;
      end
    endcase
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_par_drive_gate: assert property ((r.mode == arp_pkg::MODE_PAR && result_data_lines_oe_o[0]) |->
    (!r.cs_q && !r.rd_q)) else $error("parallel bus driven outside read");
  a_ser_mode_pick: assert property ((ce_i && p.cs_n && p.iface_sel && !p.byte_sel) |=>
    r.mode == arp_pkg::MODE_SER) else $error("serial mode not chosen");
  a_byte_mode_pick: assert property ((ce_i && p.cs_n && p.iface_sel && p.byte_sel) |=>
    r.mode == arp_pkg::MODE_BYTE) else $error("byte mode not chosen");
  a_ser_line_role: assert property ((r.mode == arp_pkg::MODE_SER && !r.cs_q) |->
    result_data_lines_oe_o == arp_pkg::OE_SER) else $error("serial lines not enabled");
  a_byte_first_order: assert property ((ce_i && rd_fall && r.mode == arp_pkg::MODE_BYTE && !r.byte_idx
    && p.high_byte_first) |=> r.dout[5:0] == $past(head[arp_pkg::SIGN_BIT:arp_pkg::HI_LSB]))
    else $error("upper byte not first");
  a_sign_copy_lines: assert property ((r.mode == arp_pkg::MODE_PAR) |->
    (r.dout[15] == r.dout[13] && r.dout[14] == r.dout[13])) else $error("sign extension wrong");
  a_ref_follow_pin: assert property ((ce_i && p.ref_select) |=> int_ref_en_o)
    else $error("reference enable not following select");
  a_byte_two_strobes: assert property ((ce_i && rd_end && r.mode == arp_pkg::MODE_BYTE && !r.byte_idx
    && !p.cs_n) |=> (r.byte_idx && r.cnt >= $past(r.cnt))) else $error("result popped after one byte");
  a_ser_bit_step: assert property (@(posedge sclk_i) disable iff (!arst_n_i || cs_n_i)
    (l.bit_idx != arp_pkg::LAST_BIT) |=> l.bit_idx == $past(l.bit_idx) + 4'h1)
    else $error("serial bit did not advance");

  c_par_read: cover property (r.mode == arp_pkg::MODE_PAR && rd_end && r.cnt != arp_pkg::CNT_EMPTY);
  c_byte_pair: cover property (r.mode == arp_pkg::MODE_BYTE && rd_end && r.byte_idx);
  c_ser_frame: cover property (r.mode == arp_pkg::MODE_SER && cs_fall && r.cnt == arp_pkg::CNT_FULL);
  c_buf_full: cover property (r.cnt == arp_pkg::CNT_FULL && res_valid_i);
endmodule

// File: rtl/arp_pkg.sv
/*
  constants, modes and carrier types for the result output port.
  assumes one host at a time and strap pins held steady while chip select is low.
*/
// Operation
// - with interface select low the lines form a parallel bus driven only while chip select and read are both low.
// - with interface select high and byte select low the port runs the serial mode.
// - with interface select and byte select both high the port runs a byte-wide bus on lines 7 to 0.
// - in serial mode line 7 becomes serial output a and line 8 serial output b, both shifting result data.
// - in byte mode high byte first set to 1 sends the upper byte first, and 0 sends the lower byte first.
// - in byte mode each byte has its msb on line 7 and its lsb on line 0.
// - in full parallel mode lines 14 and 15 copy result bit 13 as a sign extension.
// - reference select high enables the internal reference and low disables it.
// - in byte mode one result takes two read strobes, one byte per strobe.
// - in serial mode the falling chip select enables the serial outputs and shows the msb.
// - in serial mode each later bit moves onto both serial outputs at a rising serial clock.
package arp_pkg;
  localparam int RES_W      = 14;
  localparam int BUS_W      = 16;
  localparam int BYTE_W     = 8;
  localparam int SIGN_BIT   = 13;
  localparam int HI_LSB     = 8;
  localparam int SER_A_LINE = 7;
  localparam int SER_B_LINE = 8;
  localparam int HBF_LINE   = 14;
  localparam int BSEL_LINE  = 15;
  localparam int BUF_DEPTH  = 2;

  localparam logic [3:0]       LAST_BIT  = 4'hd;
  localparam logic [3:0]       FIRST_BIT = 4'h0;
  localparam logic [1:0]       CNT_FULL  = 2'h2;
  localparam logic [1:0]       CNT_EMPTY = 2'h0;
  localparam logic [BUS_W-1:0] OE_ALL    = 16'hffff;
  localparam logic [BUS_W-1:0] OE_BYTE   = 16'h00ff;
  localparam logic [BUS_W-1:0] OE_SER    = 16'h0180;
  localparam logic [BUS_W-1:0] OE_NONE   = 16'h0000;

  typedef enum logic [1:0] {
    MODE_PAR,
    MODE_SER,
    MODE_BYTE
  } arp_mode_type;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic iface_sel;
    logic byte_sel;
    logic high_byte_first;
    logic ref_select;
  } arp_pins_type;

  // strobes idle high, straps idle low
  localparam arp_pins_type PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, default: 1'b0};

  typedef struct packed {
    logic [BUF_DEPTH-1:0][RES_W-1:0] mem;
    logic                            wptr;
    logic                            rptr;
    logic [1:0]                      cnt;
    logic                            cs_q;
    logic                            rd_q;
    logic                            byte_idx;
    logic [BUS_W-1:0]                dout;
    logic [RES_W-1:0]                word_a;
    logic [RES_W-1:0]                word_b;
    arp_mode_type                    mode;
    logic                            ref_en;
  } arp_state_type;

  typedef struct packed {
    logic [3:0] bit_idx;
  } arp_link_type;
endpackage

// File: rtl/arp_sync2.sv
/*
  two flip-flop synchroniser for a group of pin levels.
  assumes each bit is a level; no relation between bits is kept.
*/
`timescale 1ns/1ps
module arp_sync2 #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [1:0][W-1:0] stage;
  logic [1:0][W-1:0] next_stage;

  // first stage feeds only the second
  always_comb begin
    next_stage = stage;
    if (ce_i) begin
      next_stage[0] = d_i;
      next_stage[1] = stage[0];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // reset to the idle pin level, so release shows no false edge
      stage <= {2{RST}};
    end else begin
      stage <= next_stage;
    end
  end

  assign q_o = stage[1];
endmodule

// File: test/arp_host.sv
/*
  host model for the result output port: chip select, read strobe, serial clock and strap levels.
  assumes the bench calls its tasks one at a time, just after a rising clk_i edge.
*/
`timescale 1ns/1ps
module arp_host (
  input  wire logic        clk_i,
  input  wire logic [15:0] lines_i,
  input  wire logic [15:0] oe_i,
  output logic             cs_n_o,
  output logic             rd_n_o,
  output logic             sclk_o,
  output logic             iface_o,
  output logic [15:0]      drv_o,
  output logic [15:0]      drv_en_o
);
  logic bsel = 1'b0;
  logic hbf  = 1'b0;
  initial begin
    cs_n_o  = 1'b1;
    rd_n_o  = 1'b1;
    sclk_o  = 1'b0;
    iface_o = 1'b0;
  end
  // straps on lines 15 and 14, lines 13 to 9 held at ground, only while iface_o is high
  assign drv_o    = {bsel, hbf, 14'h0000};
  assign drv_en_o = iface_o ? 16'hfe00 : 16'h0000;
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  // only called with chip select high
  task automatic set_mode(input logic i, input logic b, input logic h);
    iface_o = i;
    bsel = b;
    hbf = h;
    wait_clk(4);
  endtask
  task automatic select(input logic on);
    cs_n_o = ~on;
    wait_clk(5);
  endtask
  // level held 4 clk so the synchroniser cannot miss it
  task automatic strobe(output logic [15:0] d, output logic [15:0] oe);
    rd_n_o = 1'b0;
    wait_clk(4);
    d = lines_i;
    oe = oe_i;
    rd_n_o = 1'b1;
    wait_clk(4);
  endtask
  // 12 ns period, runs only inside a frame
  task automatic sclk_pulse(output logic [15:0] d);
    #5 sclk_o = 1'b1;
    #6 sclk_o = 1'b0;
    d = lines_i;
    #1;
  endtask
endmodule

// File: test/adc_result_output_port_bench.sv
/*
  self-checking bench: parallel, byte and serial reads, buffer refusal, reference select.
  assumes the host model in arp_host.sv and the design package arp_pkg.
*/
`timescale 1ns/1ps
module adc_result_output_port_bench;
  logic        clk_i;
  logic        arst_n_i;
  logic        ce;
  logic        res_valid;
  logic [13:0] res_data;
  logic        ref_sel;
  logic        res_ready;
  logic        int_ref_en;
  logic        cs_n;
  logic        rd_n;
  logic        sclk;
  logic        iface;
  logic [15:0] lines_o;
  logic [15:0] lines_oe;
  logic [15:0] lines_i;
  logic [15:0] drv;
  logic [15:0] drv_en;
  logic [15:0] d;
  logic [15:0] oe;
  logic [13:0] exp_a;
  logic [13:0] exp_b;
  int          n_errors  = 0;
  int          tests_run = 0;

  always #25 clk_i = ~clk_i;
  // an undriven line shows the inverse of its last value, never a kind guess
  assign lines_i = (lines_oe & lines_o) | (~lines_oe & drv_en & drv) | (~lines_oe & ~drv_en & ~lines_o);

  arp_output_port uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce), .res_valid_i(res_valid),
    .res_ready_o(res_ready), .res_data_i(res_data), .cs_n_i(cs_n), .rd_n_i(rd_n), .sclk_i(sclk),
    .interface_select_i(iface), .ref_select_i(ref_sel), .result_data_lines_i(lines_i),
    .result_data_lines_o(lines_o), .result_data_lines_oe_o(lines_oe), .int_ref_en_o(int_ref_en));
  arp_host host (.clk_i(clk_i), .lines_i(lines_i), .oe_i(lines_oe), .cs_n_o(cs_n), .rd_n_o(rd_n),
    .sclk_o(sclk), .iface_o(iface), .drv_o(drv), .drv_en_o(drv_en));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic push(input logic [13:0] w);
    res_data = w;
    res_valid = 1'b1;
    host.wait_clk(1);
    res_valid = 1'b0;
    // one idle edge, so back-to-back pushes never re-raise valid in the same step
    host.wait_clk(1);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    summarize();
  end

  initial begin
    clk_i = 1'b0;
    arst_n_i = 1'b0;
    ce = 1'b1;
    res_valid = 1'b0;
    res_data = 14'h0000;
    ref_sel = 1'b0;
    host.wait_clk(16);
    arst_n_i = 1'b1;
    host.wait_clk(4);
    // negative word shows the sign copies on the top lines
    push(14'h2a5c);
    host.select(1'b1);
    chk(lines_oe, 16'h0000);
    host.strobe(d, oe);
    chk(oe, 16'hffff);
    chk(d, 16'hea5c);
    chk(lines_oe, 16'h0000);
    host.select(1'b0);
    $display("parallel read done");
    for (int h = 0; h < 2; h++) begin
      host.set_mode(1'b1, 1'b1, h[0]);
      push(14'h3a96);
      host.select(1'b1);
      host.strobe(d, oe);
      chk(oe, 16'h00ff);
      chk(d & 16'h00ff, (h == 1) ? 16'h00fa : 16'h0096);
      host.strobe(d, oe);
      chk(d & 16'h00ff, (h == 1) ? 16'h0096 : 16'h00fa);
      host.select(1'b0);
    end
    $display("byte reads done");
    host.set_mode(1'b1, 1'b0, 1'b0);
    exp_a = 14'h2b4d;
    exp_b = 14'h14b2;
    push(exp_a);
    push(exp_b);
    chk({15'h0000, res_ready}, 16'h0000);
    push(14'h0fff);
    host.select(1'b1);
    chk(lines_oe, 16'h0180);
    chk({14'h0000, lines_i[8], lines_i[7]}, {14'h0000, exp_b[13], exp_a[13]});
    for (int k = 1; k < 14; k++) begin
      host.sclk_pulse(d);
      chk({14'h0000, d[8], d[7]}, {14'h0000, exp_b[13-k], exp_a[13-k]});
    end
    host.select(1'b0);
    chk(lines_oe, 16'h0000);
    chk({15'h0000, res_ready}, 16'h0001);
    // a lone word leaves the second line at zero
    push(14'h2001);
    host.select(1'b1);
    chk({14'h0000, lines_i[8], lines_i[7]}, 16'h0001);
    host.select(1'b0);
    $display("serial frame done");
    for (int r = 1; r >= 0; r--) begin
      ref_sel = r[0];
      host.wait_clk(4);
      chk({15'h0000, int_ref_en}, {15'h0000, r[0]});
    end
    $display("reference select done");
    ce = 1'b0;
    ref_sel = 1'b1;
    host.wait_clk(4);
    chk({15'h0000, int_ref_en}, 16'h0000);
    ce = 1'b1;
    host.wait_clk(4);
    chk({15'h0000, int_ref_en}, 16'h0001);
    $display("clock enable freeze done");
    summarize();
  end
endmodule
